// ==== hw/elc_defines.svh ====
/*
 Constants of the elapsed time counter and of the host that drives it.
 Assumes one 25 MHz clock shared by both ends.
*/
`ifndef ELC_DEFINES_SVH
`define ELC_DEFINES_SVH
`define ELC_MCLK_NS 40
`define ELC_CNT_W 40
`define ELC_DIV_OSC3 8
`define ELC_DIV_OSC2 20
`define ELC_CAPTURE_FUNC 8'h27
// Device register addresses on the serial port
`define ELC_A_CTRL 7'h00
`define ELC_A_PIN_FUNC 7'h01
`define ELC_A_PIN_POL 7'h02
`define ELC_A_CAP0 7'h03
`define ELC_A_CAP4 7'h07
// Control register bit positions, and the read flag bit of the command byte
`define ELC_CTRL_RUN 0
`define ELC_CTRL_SRC 1
`define ELC_CTRL_CLR 2
`define ELC_CTRL_OSC 3
`define ELC_CMD_READ 7
// Host timing
`define ELC_TRIG_HIGH_NS 10
`define ELC_REARM_NS 1000
`define ELC_SCK_HALF 8
// Host register offsets and control bits
`define ELC_H_ADDR 3'h0
`define ELC_H_WDATA 3'h1
`define ELC_H_CTRL 3'h2
`define ELC_H_STATUS 3'h3
`define ELC_H_RDATA 3'h4
`define ELC_H_START 0
`define ELC_H_TRIG 1
`endif

// ==== hw/elc_pkg.sv ====
/*
 Types of the elapsed time counter ends.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package elc_pkg;
   typedef enum logic [1:0] {ELC_D_IDLE, ELC_D_CMD, ELC_D_DATA} elc_dev_st_t;
   typedef enum logic [1:0] {ELC_H_IDLE, ELC_H_LEAD, ELC_H_XFER, ELC_H_TAIL} elc_host_st_t;
endpackage : elc_pkg

// ==== hw/elc_if.sv ====
/*
 Link between host and counter: serial port plus trigger pin.
 Assumes both ends share mclk; the pins are still treated as asynchronous.
*/
interface elc_if;
   logic chip_sel_n;
   logic sclk;
   logic mosi;
   logic miso;
   logic trig_pin;
   modport dev (input chip_sel_n, input sclk, input mosi, input trig_pin, output miso);
   modport host (output chip_sel_n, output sclk, output mosi, output trig_pin, input miso);
endinterface : elc_if

// ==== hw/elc_dev.sv ====
/*
 Elapsed time counter: 40-bit free-running counter with capture on a
 trigger pin edge or a chip-select falling edge, registers on a serial port.
 Assumes oscillator ticks are one-cycle enables on mclk.
*/
`include "elc_defines.svh"
module elc_dev import elc_pkg::*; #(
   parameter int DIV3 = `ELC_DIV_OSC3,
   parameter int DIV2 = `ELC_DIV_OSC2
) (
   input wire logic mclk,
   input wire logic rstn,
   elc_if.dev link,
   input wire logic osc3_tick,
   input wire logic osc2_tick,
   output logic ref_val_osc_sel,
   output logic capture_armed,
   output logic [`ELC_CNT_W-1:0] live_count
);
   localparam int CW = `ELC_CNT_W;

   logic [3:0] meta_r, meta_nxt, sync_r, sync_nxt, prev_r, prev_nxt;
   logic cs_fall, sck_rise, sck_fall, mosi_s, pin_edge;
   logic [3:0] ctrl_r, ctrl_nxt;
   logic [7:0] func_r, func_nxt;
   logic pol_r, pol_nxt;
   logic [4:0] div_r, div_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt, cap_r, cap_nxt;
   logic pin_lock_r, pin_lock_nxt, cs_lock_r, cs_lock_nxt;
   logic pin_cap, cs_cap, tick, osc_tick;
   logic [4:0] div_last;
   elc_dev_st_t st_r, st_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, rx_byte;
   logic [6:0] addr_r, addr_nxt;
   logic rd_r, rd_nxt;
   logic lsb_read, msb_read, wr_en;

   // Register read mux; capture bytes sit LSB first
   function automatic logic [7:0] rd_mux(input logic [6:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `ELC_A_CTRL: d = {4'h0, ctrl_r};
         `ELC_A_PIN_FUNC: d = func_r;
         `ELC_A_PIN_POL: d = {7'h00, pol_r};
         default: begin
            if (a >= `ELC_A_CAP0 && a <= `ELC_A_CAP4) begin
               d = cap_r[8*(a-`ELC_A_CAP0) +: 8];
            end
         end
      endcase
      return d;
   endfunction : rd_mux

   // Two flops on every pin before any logic looks at it
   always_comb begin
      meta_nxt = {link.trig_pin, link.mosi, link.sclk, link.chip_sel_n};
      sync_nxt = meta_r;
      prev_nxt = sync_r;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         meta_r <= 4'h1;
         sync_r <= 4'h1;
         prev_r <= 4'h1;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   // Edge detectors work on the second stage and its delayed copy
   assign cs_fall = prev_r[0] & ~sync_r[0];
   assign sck_rise = ~prev_r[1] & sync_r[1];
   assign sck_fall = prev_r[1] & ~sync_r[1];
   assign mosi_s = sync_r[2];
   // Polarity folded in before the edge, on both samples alike; flipping it cannot fake an edge
   assign pin_edge = ~(prev_r[3] ^ pol_r) & (sync_r[3] ^ pol_r);

   // Counter clock enable from the chosen oscillator divider
   always_comb begin
      osc_tick = ctrl_r[`ELC_CTRL_OSC] ? osc2_tick : osc3_tick;
      div_last = ctrl_r[`ELC_CTRL_OSC] ? 5'(DIV2 - 1) : 5'(DIV3 - 1);
      tick = osc_tick && (div_r == div_last);
      div_nxt = div_r;
      if (!ctrl_r[`ELC_CTRL_RUN]) begin
         div_nxt = 5'h00;
      end else if (osc_tick) begin
         div_nxt = (div_r >= div_last) ? 5'h00 : 5'(div_r + 5'h01);
      end
      cnt_nxt = cnt_r;
      if (!ctrl_r[`ELC_CTRL_RUN] || ctrl_r[`ELC_CTRL_CLR]) begin
         cnt_nxt = '0;
      end else if (tick) begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   // Capture and lock-out; a capture wins over a same-cycle re-arm
   always_comb begin
      pin_cap = ctrl_r[`ELC_CTRL_RUN] && ctrl_r[`ELC_CTRL_SRC]
         && (func_r == `ELC_CAPTURE_FUNC) && pin_edge && !pin_lock_r;
      cs_cap = ctrl_r[`ELC_CTRL_RUN] && !ctrl_r[`ELC_CTRL_SRC]
         && cs_fall && !cs_lock_r;
      cap_nxt = (pin_cap || cs_cap) ? cnt_r : cap_r;
      pin_lock_nxt = pin_cap || (pin_lock_r && !lsb_read);
      cs_lock_nxt = msb_read || (cs_lock_r && !lsb_read);
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         div_r <= 5'h00;
         cnt_r <= '0;
         cap_r <= '0;
         pin_lock_r <= 1'b0;
         cs_lock_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         cap_r <= cap_nxt;
         pin_lock_r <= pin_lock_nxt;
         cs_lock_r <= cs_lock_nxt;
      end
   end

   // Serial slave: command byte (read flag, address), then data bytes
   // with address increment; MSB first, sample on rise, shift on fall
   always_comb begin
      st_nxt = st_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      tx_nxt = tx_r;
      addr_nxt = addr_r;
      rd_nxt = rd_r;
      lsb_read = 1'b0;
      msb_read = 1'b0;
      wr_en = 1'b0;
      rx_byte = {sh_r[6:0], mosi_s};
      if (sync_r[0]) begin
         st_nxt = ELC_D_IDLE;
         bit_nxt = 3'h0;
      end else begin
         case (st_r)
            ELC_D_IDLE: begin
               st_nxt = ELC_D_CMD;
               bit_nxt = 3'h0;
            end
            ELC_D_CMD, ELC_D_DATA: begin
               if (sck_rise) begin
                  sh_nxt = rx_byte;
                  bit_nxt = 3'(bit_r + 3'h1);
                  if (bit_r == 3'h7) begin
                     if (st_r == ELC_D_CMD) begin
                        st_nxt = ELC_D_DATA;
                        rd_nxt = rx_byte[`ELC_CMD_READ];
                        addr_nxt = rx_byte[6:0];
                        tx_nxt = rd_mux(rx_byte[6:0]);
                     end else begin
                        addr_nxt = 7'(addr_r + 7'h01);
                        if (rd_r) begin
                           // A read counts once its last bit has gone out
                           lsb_read = (addr_r == `ELC_A_CAP0);
                           msb_read = (addr_r == `ELC_A_CAP4);
                           tx_nxt = rd_mux(7'(addr_r + 7'h01));
                        end else begin
                           wr_en = 1'b1;
                        end
                     end
                  end
               end else if (sck_fall && bit_r != 3'h0 && rd_r && st_r == ELC_D_DATA) begin
                  tx_nxt = {tx_r[6:0], 1'b0};
               end
            end
            default: begin
               st_nxt = ELC_D_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_r <= ELC_D_IDLE;
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         addr_r <= 7'h00;
         rd_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         tx_r <= tx_nxt;
         addr_r <= addr_nxt;
         rd_r <= rd_nxt;
      end
   end

   // Writable registers; run rising restarts the count from zero
   always_comb begin
      ctrl_nxt = ctrl_r;
      func_nxt = func_r;
      pol_nxt = pol_r;
      if (wr_en) begin
         case (addr_r)
            `ELC_A_CTRL: ctrl_nxt = rx_byte[3:0];
            `ELC_A_PIN_FUNC: func_nxt = rx_byte;
            `ELC_A_PIN_POL: pol_nxt = rx_byte[0];
            default: ctrl_nxt = ctrl_r;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ctrl_r <= 4'h0;
         func_r <= 8'h00;
         pol_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         func_r <= func_nxt;
         pol_r <= pol_nxt;
      end
   end

   assign link.miso = tx_r[7];
   assign ref_val_osc_sel = ctrl_r[`ELC_CTRL_OSC];
   assign capture_armed = ctrl_r[`ELC_CTRL_SRC] ? !pin_lock_r : !cs_lock_r;
   assign live_count = cnt_r;

endmodule : elc_dev

// ==== hw/elc_host.sv ====
/*
 Host end: runs single-byte serial transfers and fires trigger pulses
 on software orders. Assumes the counter end on the same link.
*/
`include "elc_defines.svh"
module elc_host import elc_pkg::*; #(
   parameter int SCK_HALF = `ELC_SCK_HALF
) (
   input wire logic mclk,
   input wire logic rstn,
   elc_if.host link,
   input wire logic [2:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata
);
   localparam int TRIG_CYC = (`ELC_TRIG_HIGH_NS + `ELC_MCLK_NS - 1) / `ELC_MCLK_NS;
   localparam int REARM_CYC = (`ELC_REARM_NS + `ELC_MCLK_NS - 1) / `ELC_MCLK_NS;

   elc_host_st_t st_r, st_nxt;
   logic [7:0] cmd_r, cmd_nxt, wd_r, wd_nxt, rdat_r, rdat_nxt, rx_r, rx_nxt, out_r, out_nxt;
   logic [15:0] sh_r, sh_nxt;
   logic [7:0] div_r, div_nxt, guard_r, guard_nxt, trig_r, trig_nxt;
   logic [4:0] bitn_r, bitn_nxt;
   logic sck_r, sck_nxt, csn_r, csn_nxt, m1_r, m2_r;
   logic busy, blocked, half;

   assign busy = (st_r != ELC_H_IDLE);
   // Trigger orders are dropped during any frame, the guard after every frame, and a pulse in flight
   assign blocked = busy || (guard_r != 8'h00) || (trig_r != 8'h00);
   assign half = (div_r == 8'(SCK_HALF - 1));

   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      wd_nxt = wd_r;
      rdat_nxt = rdat_r;
      rx_nxt = rx_r;
      sh_nxt = sh_r;
      div_nxt = half ? 8'h00 : 8'(div_r + 8'h01);
      bitn_nxt = bitn_r;
      sck_nxt = sck_r;
      csn_nxt = csn_r;
      guard_nxt = (guard_r != 8'h00) ? 8'(guard_r - 8'h01) : 8'h00;
      trig_nxt = (trig_r != 8'h00) ? 8'(trig_r - 8'h01) : 8'h00;
      out_nxt = 8'h00;
      if (sw_wr) begin
         case (sw_addr)
            `ELC_H_ADDR: cmd_nxt = sw_wdata;
            `ELC_H_WDATA: wd_nxt = sw_wdata;
            `ELC_H_CTRL: begin
               if (sw_wdata[`ELC_H_TRIG] && !blocked) begin
                  trig_nxt = 8'(TRIG_CYC);
               end
            end
            default: cmd_nxt = cmd_r;
         endcase
      end
      if (sw_rd) begin
         case (sw_addr)
            `ELC_H_ADDR: out_nxt = cmd_r;
            `ELC_H_WDATA: out_nxt = wd_r;
            `ELC_H_STATUS: out_nxt = {6'h00, blocked, busy};
            `ELC_H_RDATA: out_nxt = rdat_r;
            default: out_nxt = 8'h00;
         endcase
      end
      case (st_r)
         ELC_H_IDLE: begin
            div_nxt = 8'h00;
            if (sw_wr && sw_addr == `ELC_H_CTRL && sw_wdata[`ELC_H_START]) begin
               st_nxt = ELC_H_LEAD;
               csn_nxt = 1'b0;
               sh_nxt = {cmd_r, wd_r};
               bitn_nxt = 5'h00;
            end
         end
         ELC_H_LEAD: begin
            if (half) begin
               st_nxt = ELC_H_XFER;
            end
         end
         ELC_H_XFER: begin
            if (half) begin
               sck_nxt = !sck_r;
               if (!sck_r) begin
                  rx_nxt = {rx_r[6:0], m2_r};
               end else begin
                  sh_nxt = {sh_r[14:0], 1'b0};
                  bitn_nxt = 5'(bitn_r + 5'h01);
                  if (bitn_r == 5'h0F) begin
                     st_nxt = ELC_H_TAIL;
                  end
               end
            end
         end
         ELC_H_TAIL: begin
            if (half) begin
               st_nxt = ELC_H_IDLE;
               csn_nxt = 1'b1;
               rdat_nxt = rx_r;
               guard_nxt = 8'(REARM_CYC);
            end
         end
         default: st_nxt = ELC_H_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_r <= ELC_H_IDLE;
         cmd_r <= 8'h00;
         wd_r <= 8'h00;
         rdat_r <= 8'h00;
         rx_r <= 8'h00;
         sh_r <= 16'h0000;
         div_r <= 8'h00;
         bitn_r <= 5'h00;
         sck_r <= 1'b0;
         csn_r <= 1'b1;
         guard_r <= 8'h00;
         trig_r <= 8'h00;
         out_r <= 8'h00;
         m1_r <= 1'b0;
         m2_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         wd_r <= wd_nxt;
         rdat_r <= rdat_nxt;
         rx_r <= rx_nxt;
         sh_r <= sh_nxt;
         div_r <= div_nxt;
         bitn_r <= bitn_nxt;
         sck_r <= sck_nxt;
         csn_r <= csn_nxt;
         guard_r <= guard_nxt;
         trig_r <= trig_nxt;
         out_r <= out_nxt;
         m1_r <= link.miso;
         m2_r <= m1_r;
      end
   end

   assign link.chip_sel_n = csn_r;
   assign link.sclk = sck_r;
   assign link.mosi = sh_r[15];
   assign link.trig_pin = (trig_r != 8'h00);
   assign sw_rdata = out_r;

endmodule : elc_host

// ==== sim/elc_assertions.sv ====
/*
 Wire checks on the link between host and counter.
 Assumes one mclk for both ends; instanced in tb beside the interface.
*/
module elc_assertions (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic chip_sel_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic trig_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] gap_r;
   logic [5:0] gap_nxt;

   // Idle cycles since a frame ended, saturating so long gaps stay legal
   always_comb begin
      gap_nxt = gap_r;
      if (!chip_sel_n) begin
         gap_nxt = 6'h00;
      end else if (gap_r != 6'h3F) begin
         gap_nxt = gap_r + 6'h01;
      end
   end

   // Reset counts as a long idle gap, no frame has ended yet
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         gap_r <= 6'h3F;
      end else begin
         gap_r <= gap_nxt;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_trig_one_cycle: assert property ($rose(trig_pin) |=> !trig_pin)
      else $error("trigger pulse width wrong");
   a_trig_not_framed: assert property (trig_pin |-> chip_sel_n && $past(chip_sel_n))
      else $error("trigger inside a frame");
   a_trig_rearm_gap: assert property (trig_pin |-> gap_r >= 6'h19)
      else $error("trigger too soon after frame");
   a_sclk_idle_low: assert property (chip_sel_n |-> !sclk)
      else $error("serial clock runs outside frame");
   // Lead phase plus one idle half period: sixteen low samples before the first rise
   a_frame_lead: assert property ($fell(chip_sel_n)
      |-> !sclk [*8] ##1 !sclk [*8] ##1 sclk)
      else $error("first clock rise misplaced");
   a_sclk_half_period: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("serial clock high time wrong");
   a_frame_length: assert property ($fell(chip_sel_n) |-> ##[270:274] $rose(chip_sel_n))
      else $error("frame length wrong");
   a_mosi_hold: assert property (sclk |-> $stable(mosi))
      else $error("host data moved while clock high");
   a_miso_at_rise: assert property ($rose(sclk) |-> $stable(miso))
      else $error("device data moved at clock rise");
endmodule : elc_assertions

// ==== sim/tb.sv ====
/*
 Bench: host and counter joined by the link, software port driven by tasks.
 Assumes the design files and the checker are compiled first.
*/
`include "elc_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic osc3_tick = 1'b0;
   logic osc2_tick = 1'b0;
   logic [2:0] sw_addr = 3'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [7:0] sw_rdata;
   logic ref_val_osc_sel;
   logic capture_armed;
   logic [39:0] live_count;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;

   elc_if u_elc_if ();
   elc_dev u_elc_dev (.mclk(mclk), .rstn(rstn), .link(u_elc_if.dev), .osc3_tick(osc3_tick),
      .osc2_tick(osc2_tick), .ref_val_osc_sel(ref_val_osc_sel),
      .capture_armed(capture_armed), .live_count(live_count));
   elc_host u_elc_host (.mclk(mclk), .rstn(rstn), .link(u_elc_if.host), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   elc_assertions u_elc_assertions (.mclk(mclk), .rstn(rstn),
      .chip_sel_n(u_elc_if.chip_sel_n), .sclk(u_elc_if.sclk), .mosi(u_elc_if.mosi),
      .miso(u_elc_if.miso), .trig_pin(u_elc_if.trig_pin));

   always #20 mclk = ~mclk;

   // Oscillator ticks: third every cycle, second every other cycle
   always @(posedge mclk) begin
      osc3_tick <= 1'b1;
      osc2_tick <= ~osc2_tick;
   end

   // Hang guard, well above the expected run of some 15000 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Port cycles; each ends 1 ns after an edge so outputs have settled
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge mclk);
      sw_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge mclk);
      sw_rd <= 1'b0;
      #1;
      d = sw_rdata;
   endtask : rd

   // One framed transfer: command, data, start, poll busy, fetch result
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] d, output logic [7:0] r);
      logic [7:0] s;
      wr(3'h0, cmd);
      wr(3'h1, d);
      wr(3'h2, 8'h01);
      s = 8'h01;
      for (int k = 0; k < 200 && s[0] !== 1'b0; k++) begin
         rd(3'h3, s);
      end
      rd(3'h4, r);
   endtask : xfer

   task automatic dwr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] j;
      xfer({1'b0, a}, d, j);
   endtask : dwr

   task automatic drd(input logic [6:0] a, output logic [7:0] r);
      xfer({1'b1, a}, 8'h00, r);
   endtask : drd

   // Waits out the host guard so the pulse is never silently dropped
   task automatic trig();
      repeat (30) @(posedge mclk);
      wr(3'h2, 8'h02);
      repeat (10) @(posedge mclk);
      #1;
   endtask : trig

   // Upper four capture bytes, then the low byte only when asked
   task automatic rdcap(input logic lsb, output logic [39:0] v);
      logic [7:0] b;
      v = 40'h0;
      for (int i = 4; i > 0; i--) begin
         drd(7'(3 + i), b);
         v[8*i+:8] = b;
      end
      if (lsb) begin
         drd(7'h03, b);
         v[7:0] = b;
      end
   endtask : rdcap

   task automatic t_reset();
      repeat (40) @(posedge mclk);
      #1;
      chk("live_count", live_count, 40'h0);
      chk("capture_armed", capture_armed, 40'h1);
      chk("ref_val_osc_sel", ref_val_osc_sel, 40'h0);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_rate();
      logic [39:0] c;
      dwr(7'h00, 8'h01);
      c = live_count;
      repeat (800) @(posedge mclk);
      #1;
      c = live_count - c;
      chk("rate osc3", c >= 40'h63 && c <= 40'h65, 40'h1);
      dwr(7'h00, 8'h09);
      chk("ref_val_osc_sel", ref_val_osc_sel, 40'h1);
      c = live_count;
      repeat (800) @(posedge mclk);
      #1;
      c = live_count - c;
      chk("rate osc2", c >= 40'h13 && c <= 40'h15, 40'h1);
      // Clear bit set with run still on must pin the count at zero
      dwr(7'h00, 8'h0D);
      chk("cleared count", live_count, 40'h0);
      dwr(7'h00, 8'h00);
      chk("held count", live_count, 40'h0);
      dwr(7'h00, 8'h03);
      chk("restart count", live_count <= 40'h8, 40'h1);
      $display("t_rate done");
   endtask : t_rate

   task automatic t_pin();
      logic [39:0] a;
      logic [39:0] b;
      logic [39:0] c;
      dwr(7'h01, `ELC_CAPTURE_FUNC);
      c = live_count;
      trig();
      chk("armed after pin", capture_armed, 40'h0);
      chk("window", c[39:8] <= live_count[39:8], 40'h1);
      rdcap(1'b0, a);
      chk("capture window", a[39:8] >= c[39:8], 40'h1);
      // Long wait so a wrongful recapture must change the upper bytes
      repeat (2100) @(posedge mclk);
      trig();
      rdcap(1'b1, b);
      chk("capture held", b[39:8], a[39:8]);
      chk("rearmed", capture_armed, 40'h1);
      trig();
      rdcap(1'b1, a);
      chk("second later", a > b, 40'h1);
      $display("t_pin done");
   endtask : t_pin

   task automatic t_fp();
      logic [7:0] r;
      dwr(7'h01, 8'h00);
      trig();
      chk("other function", capture_armed, 40'h1);
      dwr(7'h01, `ELC_CAPTURE_FUNC);
      dwr(7'h02, 8'h01);
      drd(7'h03, r);
      chk("armed inverted", capture_armed, 40'h1);
      trig();
      chk("inverted capture", capture_armed, 40'h0);
      dwr(7'h02, 8'h00);
      $display("t_fp done");
   endtask : t_fp

   task automatic t_cs();
      logic [7:0] p;
      logic [7:0] q;
      dwr(7'h00, 8'h01);
      drd(7'h03, p);
      drd(7'h03, q);
      chk("cs capture moves", q != p, 40'h1);
      drd(7'h07, p);
      chk("armed after msb", capture_armed, 40'h0);
      drd(7'h04, p);
      repeat (2100) @(posedge mclk);
      drd(7'h04, q);
      chk("cs capture held", q, p);
      drd(7'h03, q);
      chk("armed after lsb", capture_armed, 40'h1);
      $display("t_cs done");
   endtask : t_cs

   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_rate();
      t_pin();
      t_fp();
      t_cs();
      test_done();
   end
endmodule : tb
